// ### rtl/alert_pin_driver.sv
// pin function selection for the first alert pin
`timescale 1ns/1ps
`default_nettype none
module alert_pin_driver (
    input wire alert_pin_one_pkg::alert_pin_function_e pin_function,
    input wire logic output_polarity,
    input wire logic latched_request,
    input wire logic live_selected,
    output logic pull_low,
    output logic listen
);
    import alert_pin_one_pkg::*;

    // decide whether the open-drain pin is pulled low this cycle
    always_comb begin
        pull_low = 1'b0;
        listen = 1'b0;
        unique case (pin_function)
            FUNC_LATCHED_ALERT: begin
                pull_low = latched_request;
            end
            FUNC_GPO: begin
                // polarity zero holds the pin low, one releases it high
                pull_low = ~output_polarity;
            end
            FUNC_CONVERSION_TRIGGER_INPUT_INPUT: begin
                listen = 1'b1;
            end
            FUNC_LIVE_COMPARE: begin
                pull_low = live_selected;
            end
        endcase
    end

endmodule
`default_nettype wire

// ### rtl/alert_pin_one_pkg.sv
// shared constants and types for the first alert pin configuration block
package alert_pin_one_pkg;

    // command code under which the setup word is reached over the serial bus
    localparam logic [7:0] CMD_ALERT_PIN_ONE_SETUP = 8'hd5;

    // setup word geometry and reset value
    localparam int SETUP_WIDTH = 16;
    localparam logic [15:0] SETUP_RESET = 16'h8000;

    // number of alert sources with an enable bit, and where their field sits
    localparam int SRC_COUNT = 13;
    localparam int ENABLE_LSB = 3;
    localparam int ENABLE_MSB = 15;

    // enable bit positions inside the setup word
    localparam int SWITCH_DEGRADED_ALERT_ENABLE_BIT = 15;
    localparam int OUT_OVERCURRENT_FAULT_ALERT_ENABLE_BIT = 14;
    localparam int IN_OVERVOLT_FAULT_ALERT_ENABLE_BIT = 13;
    localparam int IN_UNDERVOLT_FAULT_ALERT_ENABLE_BIT = 12;
    localparam int COMM_LOGIC_FAULT_ALERT_ENABLE_BIT = 11;
    localparam int OUT_OVERCURRENT_WARN_ALERT_ENABLE_BIT = 10;
    localparam int SECOND_CURRENT_WARN_ALERT_ENABLE_BIT = 9;
    localparam int IN_OVERVOLT_WARN_ALERT_ENABLE_BIT = 8;
    localparam int IN_UNDERVOLT_WARN_ALERT_ENABLE_BIT = 7;
    localparam int AUX_OVERVOLT_WARN_ALERT_ENABLE_BIT = 6;
    localparam int AUX_UNDERVOLT_WARN_ALERT_ENABLE_BIT = 5;
    localparam int CURRENT_LIMIT_ALERT_ENABLE_BIT = 4;
    localparam int OVERPOWER_WARN_ALERT_ENABLE_BIT = 3;

    // pin function field and polarity bit
    localparam int FUNCTION_MSB = 2;
    localparam int FUNCTION_LSB = 1;
    localparam int OUTPUT_POLARITY_BIT = 0;

    // width of the comparator source index
    localparam int SELECT_WIDTH = 4;

    // what the pin does
    typedef enum logic [1:0] {
        FUNC_LATCHED_ALERT = 2'b00,
        FUNC_GPO = 2'b01,
        FUNC_CONVERSION_TRIGGER_INPUT_INPUT = 2'b10,
        FUNC_LIVE_COMPARE = 2'b11
    } alert_pin_function_e;

endpackage

// ### rtl/alert_pin_one_setup.sv
// setup register and pin logic for the first alert-capable pin
`timescale 1ns/1ps
`default_nettype none

// How it works
// - degraded switch alerts, enable resets to one
// - output overcurrent fault alerts when enabled
// - input overvoltage fault alerts when enabled
// - input undervoltage fault alerts when enabled
// - comm or logic fault alerts when enabled
// - output overcurrent warning alerts when enabled
// - second current warning alerts when enabled
// - input overvoltage warning alerts when enabled
// - input undervoltage warning alerts when enabled
// - aux overvoltage warning alerts when enabled
// - aux undervoltage warning alerts when enabled
// - current limit fault alerts when enabled
// - overpower warning alerts when enabled
// - function 00 gives latched alert output
// - function 01 gives general purpose output
// - function 10 listens for conversion trigger
// - function 11 follows live selected status
// - polarity bit sets general purpose level
module alert_pin_one_setup #(
    parameter int SRC_COUNT = alert_pin_one_pkg::SRC_COUNT,
    parameter int SELECT_WIDTH = alert_pin_one_pkg::SELECT_WIDTH
) (
    input wire logic ref_clk,
    input wire logic resetn,
    // command port from the serial management front end
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_done,
    output logic cmd_unsupported,
    output logic [15:0] cmd_rdata,
    // latched and live status from the fault monitor, msb is bit 15 source
    input wire logic [SRC_COUNT-1:0] status_latched,
    input wire logic [SRC_COUNT-1:0] status_live,
    input wire logic [SELECT_WIDTH-1:0] compare_select,
    // the open-drain pin as three signals
    input wire logic alert_pin_one_in,
    output logic alert_pin_one_out,
    output logic alert_pin_one_oe_n,
    // side outputs
    output logic alert_request,
    output logic conversion_trigger_input
);
    import alert_pin_one_pkg::*;

    // ------------------------------------------------------------------
    // setup word and its fields
    // ------------------------------------------------------------------

    // the one software visible word
    logic [SETUP_WIDTH-1:0] alert_pin_one_setup;
    logic [SETUP_WIDTH-1:0] next_alert_pin_one_setup;

    // field views of the setup word
    logic [SRC_COUNT-1:0] enables;
    alert_pin_function_e alert_pin_function;
    logic output_polarity;

    // named views of each enable, kept for readability of the map
    logic switch_degraded_alert_enable;
    logic out_overcurrent_fault_alert_enable;
    logic in_overvolt_fault_alert_enable;
    logic in_undervolt_fault_alert_enable;
    logic comm_logic_fault_alert_enable;
    logic out_overcurrent_warn_alert_enable;
    logic second_current_warn_alert_enable;
    logic in_overvolt_warn_alert_enable;
    logic in_undervolt_warn_alert_enable;
    logic aux_overvolt_warn_alert_enable;
    logic aux_undervolt_warn_alert_enable;
    logic current_limit_alert_enable;
    logic overpower_warn_alert_enable;

    // command answer registers
    logic next_cmd_done;
    logic next_cmd_unsupported;
    logic [15:0] next_cmd_rdata;

    // pin state registers
    logic next_alert_pin_one_out;
    logic next_alert_pin_one_oe_n;
    logic next_alert_request;
    logic next_conversion_trigger_input;

    // last sampled pin level, used for the trigger edge
    logic pin_prev;
    logic next_pin_prev;

    // combinational results of the two helper modules
    logic latched_request;
    logic live_selected;
    logic pull_low;
    logic listen;

    // decoded command hit
    logic setup_hit;

    // ------------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------------

    // the enable field runs from bit 15 down to bit 3, source index is
    // the bit position minus the field base
    assign enables = alert_pin_one_setup[ENABLE_MSB:ENABLE_LSB];
    assign alert_pin_function = alert_pin_function_e'(
        alert_pin_one_setup[FUNCTION_MSB:FUNCTION_LSB]);
    assign output_polarity = alert_pin_one_setup[OUTPUT_POLARITY_BIT];

    // individual enable bits
    assign switch_degraded_alert_enable =
        alert_pin_one_setup[SWITCH_DEGRADED_ALERT_ENABLE_BIT];
    assign out_overcurrent_fault_alert_enable =
        alert_pin_one_setup[OUT_OVERCURRENT_FAULT_ALERT_ENABLE_BIT];
    assign in_overvolt_fault_alert_enable =
        alert_pin_one_setup[IN_OVERVOLT_FAULT_ALERT_ENABLE_BIT];
    assign in_undervolt_fault_alert_enable =
        alert_pin_one_setup[IN_UNDERVOLT_FAULT_ALERT_ENABLE_BIT];
    assign comm_logic_fault_alert_enable =
        alert_pin_one_setup[COMM_LOGIC_FAULT_ALERT_ENABLE_BIT];
    assign out_overcurrent_warn_alert_enable =
        alert_pin_one_setup[OUT_OVERCURRENT_WARN_ALERT_ENABLE_BIT];
    assign second_current_warn_alert_enable =
        alert_pin_one_setup[SECOND_CURRENT_WARN_ALERT_ENABLE_BIT];
    assign in_overvolt_warn_alert_enable =
        alert_pin_one_setup[IN_OVERVOLT_WARN_ALERT_ENABLE_BIT];
    assign in_undervolt_warn_alert_enable =
        alert_pin_one_setup[IN_UNDERVOLT_WARN_ALERT_ENABLE_BIT];
    assign aux_overvolt_warn_alert_enable =
        alert_pin_one_setup[AUX_OVERVOLT_WARN_ALERT_ENABLE_BIT];
    assign aux_undervolt_warn_alert_enable =
        alert_pin_one_setup[AUX_UNDERVOLT_WARN_ALERT_ENABLE_BIT];
    assign current_limit_alert_enable =
        alert_pin_one_setup[CURRENT_LIMIT_ALERT_ENABLE_BIT];
    assign overpower_warn_alert_enable =
        alert_pin_one_setup[OVERPOWER_WARN_ALERT_ENABLE_BIT];

    // the gate takes the enables in field order; rebuild it from the
    // named bits so a misplaced constant shows up as a mismatch
    logic [SRC_COUNT-1:0] gate_enables;
    assign gate_enables = {
        switch_degraded_alert_enable,
        out_overcurrent_fault_alert_enable,
        in_overvolt_fault_alert_enable,
        in_undervolt_fault_alert_enable,
        comm_logic_fault_alert_enable,
        out_overcurrent_warn_alert_enable,
        second_current_warn_alert_enable,
        in_overvolt_warn_alert_enable,
        in_undervolt_warn_alert_enable,
        aux_overvolt_warn_alert_enable,
        aux_undervolt_warn_alert_enable,
        current_limit_alert_enable,
        overpower_warn_alert_enable
    };

    // ------------------------------------------------------------------
    // helper modules
    // ------------------------------------------------------------------

    // enable gating and live source pick
    alert_source_gate #(
        .SRC_COUNT(SRC_COUNT),
        .SELECT_WIDTH(SELECT_WIDTH)
    ) u_gate (
        .enables(gate_enables),
        .status_latched(status_latched),
        .status_live(status_live),
        .compare_select(compare_select),
        .latched_request(latched_request),
        .live_selected(live_selected)
    );

    // pin function mux
    alert_pin_driver u_driver (
        .pin_function(alert_pin_function),
        .output_polarity(output_polarity),
        .latched_request(latched_request),
        .live_selected(live_selected),
        .pull_low(pull_low),
        .listen(listen)
    );

    // ------------------------------------------------------------------
    // command handling
    // ------------------------------------------------------------------

    // only one command code belongs to this block
    assign setup_hit = (cmd_code == CMD_ALERT_PIN_ONE_SETUP);

    // write stores the whole word, read returns the stored word; any
    // other code is answered with a refusal and zero data so the front
    // end can nack it instead of hanging
    always_comb begin
        next_alert_pin_one_setup = alert_pin_one_setup;
        next_cmd_done = 1'b0;
        next_cmd_unsupported = 1'b0;
        next_cmd_rdata = cmd_rdata;
        if (cmd_valid) begin
            if (setup_hit) begin
                next_cmd_done = 1'b1;
                if (cmd_write) begin
                    // every bit is writable, none reserved
                    next_alert_pin_one_setup = cmd_wdata;
                    next_cmd_rdata = cmd_wdata;
                end else begin
                    next_cmd_rdata = alert_pin_one_setup;
                end
            end else begin
                // foreign code: refuse, leave setup untouched
                next_cmd_unsupported = 1'b1;
                next_cmd_rdata = 16'h0000;
            end
        end
    end

    // setup word and answer registers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            // reset value keeps the degraded switch alert armed
            alert_pin_one_setup <= SETUP_RESET;
            cmd_done <= 1'b0;
            cmd_unsupported <= 1'b0;
            cmd_rdata <= 16'h0000;
        end else begin
            alert_pin_one_setup <= next_alert_pin_one_setup;
            cmd_done <= next_cmd_done;
            cmd_unsupported <= next_cmd_unsupported;
            cmd_rdata <= next_cmd_rdata;
        end
    end

    // ------------------------------------------------------------------
    // pin drive and trigger detection
    // ------------------------------------------------------------------

    // the pin is open-drain: its data is always low and only the enable
    // moves; a high level comes from the board pull-up. the trigger is
    // a rising edge seen only while the pin listens; a mode change into
    // listen while our own drive holds the wire low can count one edge
    // from the release, since pin_prev keeps tracking the wire in every mode
    always_comb begin
        next_alert_pin_one_out = 1'b0;
        next_alert_pin_one_oe_n = ~pull_low;
        next_alert_request = latched_request;
        next_pin_prev = alert_pin_one_in;
        next_conversion_trigger_input =
            listen & alert_pin_one_in & ~pin_prev;
    end

    // pin registers; the pin is released at reset since the latched
    // request cannot exist before status arrives
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            alert_pin_one_out <= 1'b0;
            alert_pin_one_oe_n <= 1'b1;
            alert_request <= 1'b0;
            conversion_trigger_input <= 1'b0;
            // idle line is high through the pull-up
            pin_prev <= 1'b1;
        end else begin
            alert_pin_one_out <= next_alert_pin_one_out;
            alert_pin_one_oe_n <= next_alert_pin_one_oe_n;
            alert_request <= next_alert_request;
            conversion_trigger_input <= next_conversion_trigger_input;
            pin_prev <= next_pin_prev;
        end
    end

endmodule
`default_nettype wire

// ### rtl/alert_source_gate.sv
// gating of fault and warning status bits by their alert enables
`timescale 1ns/1ps
`default_nettype none
module alert_source_gate #(
    parameter int SRC_COUNT = alert_pin_one_pkg::SRC_COUNT,
    parameter int SELECT_WIDTH = alert_pin_one_pkg::SELECT_WIDTH
) (
    input wire logic [SRC_COUNT-1:0] enables,
    input wire logic [SRC_COUNT-1:0] status_latched,
    input wire logic [SRC_COUNT-1:0] status_live,
    input wire logic [SELECT_WIDTH-1:0] compare_select,
    output logic latched_request,
    output logic live_selected
);
    import alert_pin_one_pkg::*;

    // per-source gated request
    logic [SRC_COUNT-1:0] gated;

    // each source passes only while its enable is one
    genvar g;
    generate
        for (g = 0; g < SRC_COUNT; g++) begin : gen_gate
            assign gated[g] = status_latched[g] & enables[g];
        end
    endgenerate

    // latched request is the or of all gated sources; the live bit is
    // picked by index, an index past the last source reads as quiet
    always_comb begin
        latched_request = |gated;
        live_selected = 1'b0;
        if (compare_select < SELECT_WIDTH'(SRC_COUNT)) begin
            live_selected = status_live[compare_select];
        end
    end

endmodule
`default_nettype wire

// ### sim/alert_line_host.sv
// open-drain alert line with its pull-up and the host that may sink it
`timescale 1ns/1ps
`default_nettype none
module alert_line_host (
    input wire logic pin_out, // device data, low when it sinks
    input wire logic pin_oe_n, // device enable, low while it drives
    input wire logic host_pull_low, // host side sinking the line
    output logic pin_level
);
    // pull-up wins unless someone sinks; never shows a stale level
    assign pin_level = ~((~pin_oe_n & ~pin_out) | host_pull_low);
endmodule
`default_nettype wire

// ### sim/alert_pin_one_monitor.sv
// checker for the first alert pin setup block
`timescale 1ns/1ps
`default_nettype none
module alert_pin_one_monitor #(
    parameter int SRC_COUNT = 13,
    parameter int SELECT_WIDTH = 4
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_done,
    input wire logic cmd_unsupported,
    input wire logic [15:0] cmd_rdata,
    input wire logic [SRC_COUNT-1:0] status_latched,
    input wire logic [SRC_COUNT-1:0] status_live,
    input wire logic [SELECT_WIDTH-1:0] compare_select,
    input wire logic alert_pin_one_in,
    input wire logic alert_pin_one_out,
    input wire logic alert_pin_one_oe_n,
    input wire logic alert_request,
    input wire logic conversion_trigger_input
);
    import alert_pin_one_pkg::*;
    logic [15:0] shadow; // mirror of the setup word, rebuilt from commands
    logic [15:0] next_shadow;
    logic hit; // command addressed to this block
    logic req_now; // enabled latched status as seen this edge
    logic live_bit; // selected live status, zero past the last source
    logic [1:0] func;
    assign hit = cmd_valid && cmd_code == CMD_ALERT_PIN_ONE_SETUP;
    assign req_now = |(status_latched & shadow[15:3]);
    assign live_bit = (compare_select < SRC_COUNT) &&
        status_live[compare_select];
    assign func = shadow[2:1];
    // mirror follows writes only, so refused codes cannot disturb it
    always_comb begin
        next_shadow = shadow;
        if (hit && cmd_write)
            next_shadow = cmd_wdata;
    end
    always_ff @(posedge ref_clk) begin
        shadow <= resetn ? next_shadow : SETUP_RESET;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    property p_quiet; !$past(resetn) |-> !alert_request && alert_pin_one_oe_n
        && !cmd_done && !conversion_trigger_input; endproperty
    a_quiet: assert property (p_quiet) else $error("not idle after reset");
    property p_done; $past(resetn) |-> cmd_done == $past(hit); endproperty
    a_done: assert property (p_done) else $error("done pulse wrong");
    property p_refuse; $past(resetn) && $past(cmd_valid && !hit) |->
        cmd_unsupported && cmd_rdata == 16'h0000; endproperty
    a_refuse: assert property (p_refuse) else $error("refusal wrong");
    property p_read; $past(resetn) && $past(hit && !cmd_write) |->
        cmd_rdata == $past(shadow); endproperty
    a_read: assert property (p_read) else $error("read data wrong");
    property p_request; $past(resetn) |-> alert_request == $past(req_now);
    endproperty
    a_request: assert property (p_request) else $error("request wrong");
    property p_latched; $past(resetn) && $past(func) == 2'b00 |->
        alert_pin_one_oe_n == !$past(req_now) && !alert_pin_one_out;
    endproperty
    a_latched: assert property (p_latched) else $error("latched pin wrong");
    property p_gpo; $past(resetn) && $past(func) == 2'b01 |->
        alert_pin_one_oe_n == $past(shadow[0]); endproperty
    a_gpo: assert property (p_gpo) else $error("gpo level wrong");
    property p_listen; $past(resetn) && $past(func) == 2'b10 |->
        alert_pin_one_oe_n; endproperty
    a_listen: assert property (p_listen) else $error("input pin driven");
    property p_live; $past(resetn) && $past(func) == 2'b11 |->
        alert_pin_one_oe_n == !$past(live_bit); endproperty
    a_live: assert property (p_live) else $error("live pin wrong");
    property p_trigger; $past(resetn) && $past(resetn, 2) |->
        conversion_trigger_input == ($past(func) == 2'b10 &&
        $past(alert_pin_one_in) && !$past(alert_pin_one_in, 2)); endproperty
    a_trigger: assert property (p_trigger) else $error("trigger wrong");
endmodule
bind alert_pin_one_setup alert_pin_one_monitor #(
    .SRC_COUNT(SRC_COUNT), .SELECT_WIDTH(SELECT_WIDTH)) u_monitor (
    .ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_done(cmd_done), .cmd_unsupported(cmd_unsupported),
    .cmd_rdata(cmd_rdata), .status_latched(status_latched),
    .status_live(status_live), .compare_select(compare_select),
    .alert_pin_one_in(alert_pin_one_in),
    .alert_pin_one_out(alert_pin_one_out),
    .alert_pin_one_oe_n(alert_pin_one_oe_n), .alert_request(alert_request),
    .conversion_trigger_input(conversion_trigger_input));
`default_nettype wire

// ### sim/alert_pin_one_setup_tb_top.sv
// self-checking bench for the first alert pin setup block
`timescale 1ns/1ps
`default_nettype none
module alert_pin_one_setup_tb_top;
    import alert_pin_one_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    logic [SRC_COUNT-1:0] status_latched = 13'h1000; // degraded switch set
    logic [SRC_COUNT-1:0] status_live = 13'h0000;
    logic [SELECT_WIDTH-1:0] compare_select = 4'h0;
    logic host_pull_low = 1'b0;
    logic pin_level, cmd_done, cmd_unsupported, pin_out, pin_oe_n, req, trig;
    logic [15:0] cmd_rdata;
    logic [16:0] expect_q[$]; // {refused, rdata} noted per command
    logic [15:0] setup_model = SETUP_RESET; // what the setup word should hold
    logic [15:0] word;
    logic [7:0] pulses;
    int errors = 0;
    int checks = 0;
    integer seed = 36096;
    always #12.5 ref_clk = ~ref_clk;
    alert_pin_one_setup DUT (.ref_clk(ref_clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_done(cmd_done),
        .cmd_unsupported(cmd_unsupported), .cmd_rdata(cmd_rdata),
        .status_latched(status_latched), .status_live(status_live),
        .compare_select(compare_select), .alert_pin_one_in(pin_level),
        .alert_pin_one_out(pin_out), .alert_pin_one_oe_n(pin_oe_n),
        .alert_request(req), .conversion_trigger_input(trig));
    alert_line_host u_host (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .host_pull_low(host_pull_low), .pin_level(pin_level));
    task automatic compare_cmd(input logic [16:0] got, input logic [16:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic compare_pin(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        compare_cmd({1'b0, 16'(expect_q.size())}, 17'h00000);
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one command per falling edge; valid stays up for back-to-back use
    task automatic send(input logic wr, input logic [7:0] code,
        input logic [15:0] data);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        cmd_wdata = data;
        if (code != CMD_ALERT_PIN_ONE_SETUP)
            expect_q.push_back({1'b1, 16'h0000});
        else if (wr) begin
            setup_model = data;
            expect_q.push_back({1'b0, data});
        end else
            expect_q.push_back({1'b0, setup_model});
    endtask
    task automatic idle();
        @(negedge ref_clk);
        cmd_valid = 1'b0;
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        setup_model = SETUP_RESET;
        repeat (4) @(negedge ref_clk);
        resetn = 1'b1;
    endtask
    // pin level and request worked out from the setup word and status
    function automatic logic [2:0] pin_expect();
        logic r;
        r = |(status_latched & setup_model[15:3]);
        case (setup_model[2:1])
            2'b00: pin_expect = {1'b0, ~r, r};
            2'b01: pin_expect = {1'b0, setup_model[0], r};
            2'b10: pin_expect = {1'b0, 1'b1, r};
            default: pin_expect = {1'b0, ~((compare_select < SRC_COUNT) &
                status_live[compare_select]), r};
        endcase
    endfunction
    // two edges cover setup landing and the registered pin stage
    task automatic check_pin();
        repeat (2) @(negedge ref_clk);
        compare_pin({5'h00, pin_out, pin_oe_n, req}, {5'h00, pin_expect()});
    endtask
    // answers are paired with the oldest note as they appear
    always @(negedge ref_clk) begin
        if (resetn && (cmd_done === 1'b1 || cmd_unsupported === 1'b1)) begin
            if (expect_q.size() == 0)
                compare_cmd({cmd_unsupported, cmd_rdata}, 17'h1ffff);
            else
                compare_cmd({cmd_unsupported, cmd_rdata}, expect_q.pop_front());
        end
    end
    // a hang costs a mismatch; the run needs well under 2000 cycles
    initial begin
        #200000;
        errors++;
        finish_test();
    end
    initial begin
        do_reset();
        send(1'b0, CMD_ALERT_PIN_ONE_SETUP, 16'h0000);
        idle();
        check_pin();
        // each source alone enabled, then all but it enabled
        for (int i = 0; i < SRC_COUNT; i++) begin
            send(1'b1, CMD_ALERT_PIN_ONE_SETUP, 16'h0008 << i);
            idle();
            status_latched = 13'h0001 << i;
            check_pin();
            send(1'b1, CMD_ALERT_PIN_ONE_SETUP, ~(16'h0008 << i) & 16'hfff8);
            idle();
            check_pin();
        end
        // random words in every mode, read straight back
        repeat (12) begin
            status_latched = 13'($random(seed));
            status_live = 13'($random(seed));
            compare_select = 4'($random(seed));
            send(1'b1, CMD_ALERT_PIN_ONE_SETUP, 16'($random(seed)));
            send(1'b0, CMD_ALERT_PIN_ONE_SETUP, 16'h0000);
            idle();
            check_pin();
        end
        // general purpose output ignores the alert request
        status_latched = 13'h1fff;
        for (int p = 0; p < 2; p++) begin
            send(1'b1, CMD_ALERT_PIN_ONE_SETUP, {13'h1fff, 2'b01, p[0]});
            idle();
            check_pin();
        end
        // live mode over every select value, past the last source too
        send(1'b1, CMD_ALERT_PIN_ONE_SETUP, 16'h0006);
        idle();
        status_live = 13'($random(seed));
        for (int s = 0; s < 16; s++) begin
            compare_select = s[3:0];
            check_pin();
        end
        // host pulses the line: only the input mode may count a trigger
        for (int m = 0; m < 2; m++) begin
            send(1'b1, CMD_ALERT_PIN_ONE_SETUP, m ? 16'hfffc : 16'h0000);
            idle();
            check_pin();
            host_pull_low = 1'b1;
            repeat (3) @(negedge ref_clk);
            host_pull_low = 1'b0;
            pulses = 8'h00;
            repeat (6) begin
                @(negedge ref_clk);
                pulses = pulses + {7'h00, trig};
            end
            compare_pin(pulses, {7'h00, m[0]});
        end
        // foreign codes are refused and leave the word alone
        repeat (4) begin
            word = 16'($random(seed));
            send(1'b1, (word[7:0] == 8'hd5) ? 8'h00 : word[7:0], word);
            send(1'b0, CMD_ALERT_PIN_ONE_SETUP, 16'h0000);
        end
        idle();
        // second reset in mid-run restores the power-up word
        send(1'b1, CMD_ALERT_PIN_ONE_SETUP, 16'h1234);
        idle();
        repeat (2) @(negedge ref_clk);
        do_reset();
        send(1'b0, CMD_ALERT_PIN_ONE_SETUP, 16'h0000);
        idle();
        repeat (3) @(negedge ref_clk);
        finish_test();
    end
endmodule
`default_nettype wire
